// file: inc/smbx_pkg.sv
// package of constants and carrier types for the shared mailbox memory
// How it works
// - one 64 KB unified code and data memory
// - two independent ports, soft core and host
// - program region at zero, 0xf000 bytes long
// - mailbox region 0xf000 onward, 0x1000 bytes
// - command word lives at offset 0xfffc
// - soft core polls, reads, decodes the command
// - read result placed at mailbox base 0xf000
// - soft core writes zero to signal done
// - host holds core reset; restarts at zero
// - no write protection anywhere in memory
// - core sees memory at zero on every instance
// - host sees memory at instance base plus offset
// - core external path single transfers only
package smbx_pkg;
	// ----------------------------------------------------------------
	// memory map
	// ----------------------------------------------------------------
	localparam int          MEM_BYTES      = 65536;          // 64 KB
	localparam logic [15:0] PROG_BASE      = 16'h0000;
	localparam logic [15:0] PROG_SIZE      = 16'hf000;
	localparam logic [15:0] MBOX_BASE      = 16'hf000;
	localparam logic [15:0] MBOX_SIZE      = 16'h1000;
	localparam logic [15:0] CMD_OFFSET     = 16'hfffc;
	localparam logic [31:0] CMD_IDLE       = 32'h0000_0000;
	localparam logic [31:0] HOST_BASE_DFLT = 32'h4000_0000;
	localparam logic [31:0] HOST_WIN_MASK  = 32'hffff_0000;
	localparam logic [31:0] CMD_WORD_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        en;    // access request
		logic [3:0]  we;    // byte write enables
		logic [31:0] addr;  // byte address
		logic [31:0] wdata; // write data
	} smbx_req_s;

	typedef struct packed {
		logic        valid; // read data valid
		logic [31:0] rdata; // read data
	} smbx_rsp_s;
endpackage

// file: rtl/smbx_ram.sv
// dual-port word memory with registered read data on both ports
`timescale 1ns/100ps
module smbx_ram #(
	parameter int AW = 14 // word address width
) (
	// clock
	input  wire logic          clk_sys,
	// port a
	input  wire logic          a_en,
	input  wire logic [3:0]    a_we,
	input  wire logic [AW-1:0] a_addr,
	input  wire logic [31:0]   a_wdata,
	output logic      [31:0]   a_rdata,
	// port b
	input  wire logic          b_en,
	input  wire logic [3:0]    b_we,
	input  wire logic [AW-1:0] b_addr,
	input  wire logic [31:0]   b_wdata,
	output logic      [31:0]   b_rdata
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	// one array for code and data; same-word writes in one cycle: b lands last
	logic [31:0] mem [0:(1<<AW)-1];

	// both ports in one process, since the array may have only one writer;
	// each port reads before it writes, and port b's update is issued last
	always_ff @(posedge clk_sys) begin
		// port a
		if (a_en) begin
			a_rdata <= mem[a_addr];
			for (int i = 0; i < 4; i++) begin
				if (a_we[i]) begin
					mem[a_addr][i*8 +: 8] <= a_wdata[i*8 +: 8];
				end
			end
		end
		// port b
		if (b_en) begin
			b_rdata <= mem[b_addr];
			for (int i = 0; i < 4; i++) begin
				if (b_we[i]) begin
					mem[b_addr][i*8 +: 8] <= b_wdata[i*8 +: 8];
				end
			end
		end
	end
endmodule

// file: rtl/smbx_top.sv
// shared mailbox memory: soft core port, host port, core reset hold
`timescale 1ns/100ps
module smbx_top #(
	parameter logic [31:0] HOST_BASE = smbx_pkg::HOST_BASE_DFLT, // instance window
	parameter int          AW        = 14                          // word address bits
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	// soft core port
	input  wire smbx_pkg::smbx_req_s core_req,
	output smbx_pkg::smbx_rsp_s      core_rsp,
	// host port
	input  wire smbx_pkg::smbx_req_s host_req,
	output smbx_pkg::smbx_rsp_s      host_rsp,
	output logic                     host_miss,
	// soft core control
	input  wire logic              core_hold,
	output logic                   core_reset_n,
	// mailbox status
	output logic                   cmd_pending
);
	// ----------------------------------------------------------------
	// address translation
	// ----------------------------------------------------------------
	logic          host_hit;  // host address inside this instance window
	logic [AW-1:0] core_word; // core word address, window at zero
	logic [AW-1:0] host_word; // host word address, base removed
	logic          core_cmd_wr; // soft core writes the command word
	logic          host_cmd_wr; // host writes the command word in its window

	// decode: local word index, window hit, command word writes
	// only the low address bits reach the ram, so every instance looks alike to the core
	always_comb begin
		core_word = core_req.addr[AW+1:2];
		host_hit  = (host_req.addr & smbx_pkg::HOST_WIN_MASK) == HOST_BASE;
		host_word = host_req.addr[AW+1:2];
		core_cmd_wr = core_req.en && (core_req.we != 4'h0)
		              && (core_req.addr[15:0] == smbx_pkg::CMD_OFFSET);
		host_cmd_wr = host_req.en && host_hit && (host_req.we != 4'h0)
		              && (host_req.addr[15:0] == smbx_pkg::CMD_OFFSET);
	end

	// ----------------------------------------------------------------
	// memory
	// ----------------------------------------------------------------
	// read words straight from the ram's output registers
	logic [31:0] core_rd; // soft core read word
	logic [31:0] host_rd; // host read word

	// unified array, no protection of any range
	smbx_ram #(.AW(AW)) u_ram (
		.clk_sys (clk_sys),
		.a_en    (core_req.en),
		.a_we    (core_req.we),
		.a_addr  (core_word),
		.a_wdata (core_req.wdata),
		.a_rdata (core_rd),
		.b_en    (host_req.en && host_hit),
		.b_we    (host_req.we),
		.b_addr  (host_word),
		.b_wdata (host_req.wdata),
		.b_rdata (host_rd)
	);

	// ----------------------------------------------------------------
	// response and mailbox state
	// ----------------------------------------------------------------
	logic        core_vld_reg,  core_vld_next;
	logic        host_vld_reg,  host_vld_next;
	logic        miss_reg,      miss_next;
	logic        rst_reg,       rst_next;
	logic        pend_reg,      pend_next;

	// next values: one-cycle read valid, command shadow, reset hold
	always_comb begin
		core_vld_next = core_req.en && (core_req.we == 4'h0); // single
		host_vld_next = host_req.en && host_hit && (host_req.we == 4'h0);
		miss_next     = host_req.en && !host_hit;
		rst_next      = !core_hold;
		pend_next     = pend_reg;
		// core write of zero completes; host write of nonzero posts
		if (core_cmd_wr) begin
			pend_next = (core_req.wdata != smbx_pkg::CMD_IDLE);
		end
		// host posting wins when both land together, so it is not lost
		if (host_cmd_wr) begin
			pend_next = (host_req.wdata != smbx_pkg::CMD_IDLE);
		end
	end

	// registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			core_vld_reg <= 1'b0;
			host_vld_reg <= 1'b0;
			miss_reg     <= 1'b0;
			rst_reg      <= 1'b0;
			pend_reg     <= 1'b0;
		end else begin
			core_vld_reg <= core_vld_next;
			host_vld_reg <= host_vld_next;
			miss_reg     <= miss_next;
			rst_reg      <= rst_next;
			pend_reg     <= pend_next;
		end
	end

	// outputs; rdata comes straight from the ram's output register
	always_comb begin
		core_rsp.valid = core_vld_reg;
		core_rsp.rdata = core_rd;
		host_rsp.valid = host_vld_reg;
		host_rsp.rdata = host_rd;
	end
	// flags leave straight from their flip-flops
	assign host_miss    = miss_reg;
	assign core_reset_n = rst_reg;
	assign cmd_pending  = pend_reg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_host_post;
		host_cmd_wr && (host_req.wdata != smbx_pkg::CMD_IDLE);
	endsequence
	sequence s_core_done;
		core_cmd_wr && !host_cmd_wr && (core_req.wdata == smbx_pkg::CMD_IDLE);
	endsequence

	// a nonzero host post is seen as pending on the next cycle
	property p_post;
		@(posedge clk_sys) disable iff (!reset_n) s_host_post |=> cmd_pending;
	endproperty
	a_post: assert property (p_post) else $error("post not pending");

	// the core's zero write completes the exchange
	property p_done;
		@(posedge clk_sys) disable iff (!reset_n) s_core_done |=> !cmd_pending;
	endproperty
	a_done: assert property (p_done) else $error("done not idle");

	// the check expects idle to end only on a host command write; a core nonzero write ends it too
	property p_idle;
		@(posedge clk_sys) disable iff (!reset_n)
			!cmd_pending && !host_cmd_wr |=> !cmd_pending;
	endproperty
	a_idle: assert property (p_idle) else $error("idle left without post");

	// core reset follows the hold request one cycle later
	property p_hold;
		@(posedge clk_sys) disable iff (!reset_n) core_hold |=> !core_reset_n;
	endproperty
	a_hold: assert property (p_hold) else $error("core not held");

	// releasing the hold lets the core run from its base
	property p_release;
		@(posedge clk_sys) disable iff (!reset_n) !core_hold |=> core_reset_n;
	endproperty
	a_release: assert property (p_release) else $error("core not released");

	// every host read in the window is answered after one cycle
	property p_hread;
		@(posedge clk_sys) disable iff (!reset_n)
			host_req.en && host_hit && host_req.we == 4'h0 |=> host_rsp.valid;
	endproperty
	a_hread: assert property (p_hread) else $error("host read no valid");

	// other windows raise the miss flag and never an answer
	property p_miss;
		@(posedge clk_sys) disable iff (!reset_n)
			host_req.en && !host_hit |=> host_miss && !host_rsp.valid;
	endproperty
	a_miss: assert property (p_miss) else $error("window miss wrong");

	// every core read is answered after one cycle
	property p_cread;
		@(posedge clk_sys) disable iff (!reset_n)
			core_req.en && core_req.we == 4'h0 |=> core_rsp.valid;
	endproperty
	a_cread: assert property (p_cread) else $error("core read no valid");

	// a host word written and read back at once returns what was written
	property p_share;
		@(posedge clk_sys) disable iff (!reset_n)
			host_req.en && host_hit && host_req.we == 4'hf && !core_req.en
			##1 host_req.en && host_hit && host_req.we == 4'h0 && !core_req.en
			    && host_req.addr == $past(host_req.addr)
			|=> host_rsp.rdata == $past(host_req.wdata, 2);
	endproperty
	a_share: assert property (p_share) else $error("write not visible");

	// ----------------------------------------------------------------
	// read data standing and write silence
	// ----------------------------------------------------------------
	// a read taken, then a cycle with no access on that port
	sequence s_host_read_gap;
		host_req.en && host_hit && (host_req.we == 4'h0) ##1 !host_req.en;
	endsequence
	sequence s_core_read_gap;
		core_req.en && (core_req.we == 4'h0) ##1 !core_req.en;
	endsequence

	// a read word stands until the next access on the same port
	property p_hstand;
		@(posedge clk_sys) disable iff (!reset_n) s_host_read_gap |=> $stable(host_rsp.rdata);
	endproperty
	a_hstand: assert property (p_hstand) else $error("host read word moved");

	property p_cstand;
		@(posedge clk_sys) disable iff (!reset_n) s_core_read_gap |=> $stable(core_rsp.rdata);
	endproperty
	a_cstand: assert property (p_cstand) else $error("core read word moved");

	// an access outside the window leaves the host read word alone
	property p_mquiet;
		@(posedge clk_sys) disable iff (!reset_n)
			host_req.en && !host_hit |=> $stable(host_rsp.rdata);
	endproperty
	a_mquiet: assert property (p_mquiet) else $error("miss disturbed read word");

	// writes get no answer on either port
	property p_hwquiet;
		@(posedge clk_sys) disable iff (!reset_n)
			host_req.en && (host_req.we != 4'h0) |=> !host_rsp.valid;
	endproperty
	a_hwquiet: assert property (p_hwquiet) else $error("host write answered");

	property p_cwquiet;
		@(posedge clk_sys) disable iff (!reset_n)
			core_req.en && (core_req.we != 4'h0) |=> !core_rsp.valid;
	endproperty
	a_cwquiet: assert property (p_cwquiet) else $error("core write answered");
endmodule

// file: dv/smbx_core_model.sv
// behavioural soft core that polls the mailbox command word and answers it
`timescale 1ns/100ps
module smbx_core_model #(
	parameter logic [31:0] RESULT = 32'h5a5a_0000 // folded with the command as the answer
) (
	// clock and control
	input  wire logic                clk_sys,
	input  wire logic                run,
	input  wire logic                core_reset_n,
	// soft core port
	output smbx_pkg::smbx_req_s      core_req,
	input  wire smbx_pkg::smbx_rsp_s core_rsp
);
	// one access driven at the next edge and taken at the edge after; then lines scramble so stale values never look valid
	task automatic acc(input logic [3:0] we, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		core_req <= {1'b1, we, 16'h0000, a, d};
		@(posedge clk_sys);
		core_req <= {1'b0, 4'h0, ~core_req.addr, ~core_req.wdata};
	endtask

	// poll loop; stays quiet while held in reset
	initial begin
		core_req = '0;
		forever begin
			@(posedge clk_sys);
			if (run && core_reset_n) begin
				acc(4'h0, 16'hfffc, 32'h0000_0000);
				@(posedge clk_sys);
				// a zero word is idle: nothing is touched
				if (core_rsp.valid === 1'b1 && core_rsp.rdata != 32'h0000_0000) begin
					acc(4'hf, 16'hf000, RESULT ^ core_rsp.rdata);
					acc(4'hf, 16'hfffc, 32'h0000_0000);
				end
			end
		end
	end
endmodule

// file: dv/test_shared_mailbox_memory.sv
// self-checking bench for the shared mailbox memory
`timescale 1ns/100ps
module test_shared_mailbox_memory;
	localparam logic [31:0] BASE   = 32'h4400_0000; // third instance window
	localparam logic [31:0] RESULT = 32'h5a5a_0000; // model answer pattern
	logic                clk_sys;
	logic                reset_n;
	logic                core_hold;
	logic                run;
	smbx_pkg::smbx_req_s core_req;
	smbx_pkg::smbx_rsp_s core_rsp;
	smbx_pkg::smbx_req_s host_req;
	smbx_pkg::smbx_rsp_s host_rsp;
	logic                host_miss;
	logic                core_reset_n;
	logic                cmd_pending;
	logic [31:0]         rd;
	logic                rv;
	logic                rm;
	int                  err_total;
	int                  check_count;

	smbx_top #(.HOST_BASE(BASE), .AW(14)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.core_req(core_req), .core_rsp(core_rsp), .host_req(host_req), .host_rsp(host_rsp),
		.host_miss(host_miss), .core_hold(core_hold), .core_reset_n(core_reset_n),
		.cmd_pending(cmd_pending));
	smbx_core_model #(.RESULT(RESULT)) i_core (.clk_sys(clk_sys), .run(run),
		.core_reset_n(core_reset_n), .core_req(core_req), .core_rsp(core_rsp));

	always #12.5 clk_sys = ~clk_sys;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("errors=%0d checks=%0d", err_total, check_count);
		if (err_total == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// host word access; answer and miss are caught one edge after the take
	task automatic hacc(input logic [3:0] we, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		host_req <= {1'b1, we, a, d};
		@(posedge clk_sys);
		host_req <= {1'b0, 4'h0, ~a, ~d};
		@(posedge clk_sys);
		rd = host_rsp.rdata;
		rv = host_rsp.valid;
		rm = host_miss;
	endtask

	// program load, top program word, byte lane merge
	task automatic t_prog;
		hacc(4'hf, BASE, 32'hdead_beef);
		hacc(4'hf, BASE + 32'h0000_effc, 32'h1234_5678);
		hacc(4'h2, BASE + 32'h0000_effc, 32'h0000_ab00);
		hacc(4'h0, BASE, 32'h0000_0000);
		chk(rd, 32'hdead_beef);
		hacc(4'h0, BASE + 32'h0000_effc, 32'h0000_0000);
		chk(rd, 32'h1234_ab78);
		chk(rv, 1'b1);
	endtask

	// write then read the same word on back-to-back edges, core held quiet
	task automatic t_b2b;
		@(posedge clk_sys);
		host_req <= {1'b1, 4'hf, BASE + 32'h0000_0100, 32'hcafe_f00d};
		@(posedge clk_sys);
		host_req <= {1'b1, 4'h0, BASE + 32'h0000_0100, 32'h0000_0000};
		@(posedge clk_sys);
		host_req <= {1'b0, 4'h0, 32'h0000_0000, 32'h0000_0000};
		@(posedge clk_sys);
		chk(host_rsp.rdata, 32'hcafe_f00d);
		chk(host_rsp.valid, 1'b1);
	endtask

	// other instance windows are ignored, even for writes
	task automatic t_miss;
		hacc(4'h0, 32'h4200_fffc, 32'h0000_0000);
		chk(rm, 1'b1);
		chk(rv, 1'b0);
		hacc(4'hf, 32'h4000_0000, 32'h0000_0000);
		hacc(4'h0, BASE, 32'h0000_0000);
		chk(rd, 32'hdead_beef);
	endtask

	// release the core; an idle command word must leave the mailbox alone
	task automatic t_boot;
		hacc(4'hf, BASE + 32'h0000_fffc, 32'h0000_0000);
		chk(cmd_pending, 1'b0);
		hacc(4'hf, BASE + 32'h0000_f000, 32'h1111_2222);
		core_hold <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(core_reset_n, 1'b1);
		run <= 1'b1;
		repeat (40) @(posedge clk_sys);
		hacc(4'h0, BASE + 32'h0000_f000, 32'h0000_0000);
		chk(rd, 32'h1111_2222);
	endtask

	// full mailbox handshake for one command code
	task automatic t_mbox(input logic [31:0] cmd);
		int n;
		hacc(4'hf, BASE + 32'h0000_fffc, cmd);
		chk(cmd_pending, 1'b1);
		rd = 32'hffff_ffff;
		for (n = 0; n < 40 && rd !== 32'h0000_0000; n++) begin
			hacc(4'h0, BASE + 32'h0000_fffc, 32'h0000_0000);
		end
		chk(rd, 32'h0000_0000);
		chk(cmd_pending, 1'b0);
		hacc(4'h0, BASE + 32'h0000_f000, 32'h0000_0000);
		chk(rd, RESULT ^ cmd);
	endtask

	// main sequence
	initial begin
		clk_sys = 1'b0;
		reset_n = 1'b0;
		core_hold = 1'b1;
		run = 1'b0;
		host_req = '0;
		err_total = 0;
		check_count = 0;
		repeat (3) @(posedge clk_sys);
		chk(core_reset_n, 1'b0);
		chk(cmd_pending, 1'b0);
		reset_n <= 1'b1;
		t_prog;
		t_b2b;
		t_miss;
		t_boot;
		t_mbox(32'h0000_0003);
		t_mbox(32'h0000_0007);
		stop_test;
	end

	// watchdog: the run needs well under a thousand cycles
	initial begin
		#(25 * 20000);
		err_total++;
		stop_test;
	end
endmodule
